// ---- cal_seq_params.svh ----
`ifndef CAL_SEQ_PARAMS_SVH
`define CAL_SEQ_PARAMS_SVH
// Sample clock period in ps (250 MHz)
`define CLK_PERIOD_PS 4000
// Pipeline latency in half periods: 7.5 periods
`define LATENCY_HALF_CYCLES 15
`define LATENCY_FULL_CYCLES 7
// Calibration times in ms
`define CAL_NOM_MS 200
`define CAL_MAX_MS 550
`define CAL_NOM_CYCLES (`CAL_NOM_MS * 64'd1000000000 / `CLK_PERIOD_PS)
`define CAL_MAX_CYCLES (`CAL_MAX_MS * 64'd1000000000 / `CLK_PERIOD_PS)
// Serial clock period minimums in sample periods
`define SCLK_WR_MIN_CYCLES 16
`define SCLK_RD_MIN_CYCLES 66
// Sleep-mode select setup in us, and its cycle count
`define SLEEP_SETUP_US 150
`define SLEEP_SETUP_CYCLES ((`SLEEP_SETUP_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NAP_SETUP_CYCLES 1
// Least reset low time in cycles
`define RESET_LOW_MIN_CYCLES 1
`endif

// ---- cal_seq_pkg.sv ----
package cal_seq_pkg;
  typedef enum logic [2:0] {
    DEV_HOLD = 3'b001,
    DEV_CAL = 3'b010,
    DEV_RUN = 3'b100
  } dev_state_e;
  typedef enum logic [3:0] {
    HOST_POWERUP = 4'b0001,
    HOST_WAIT = 4'b0010,
    HOST_READY = 4'b0100,
    HOST_RESET = 4'b1000
  } host_state_e;
endpackage

// ---- cal_link_if.sv ----
`timescale 1ns/10ps
interface cal_link_if #(parameter int DATA_W = 12);
  logic cal_reset_n_o;
  logic cal_reset_n_oe;
  logic serial_data_out;
  logic serial_select_n;
  logic over_range;
  logic forwarded_output_clock;
  logic [DATA_W-1:0] sample_data;
  logic sample_valid;
  modport device (input cal_reset_n_o, input cal_reset_n_oe, input serial_data_out, input serial_select_n,
    output over_range, output forwarded_output_clock, output sample_data, output sample_valid);
  modport host (output cal_reset_n_o, output cal_reset_n_oe, output serial_data_out, output serial_select_n,
    input over_range, input forwarded_output_clock, input sample_data, input sample_valid);
endinterface

// ---- cal_host.sv ----
`timescale 1ns/10ps
`include "cal_seq_params.svh"
module cal_host #(
  parameter int DATA_W = 12,
  parameter longint CAL_WAIT_CYCLES = `CAL_MAX_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic recal_req_in,
  cal_link_if.host link,
  output logic data_trusted_out,
  output logic [DATA_W-1:0] sample_data_out,
  output logic sample_valid_out,
  output logic overrange_out
);
  cal_seq_pkg::host_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic valid_r, valid_nxt, or_r, or_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      cal_seq_pkg::HOST_POWERUP: begin
        state_nxt = cal_seq_pkg::HOST_WAIT; // R9
        cnt_nxt = 32'h0000_0000;
      end
      cal_seq_pkg::HOST_WAIT: begin
        if (cnt_r >= 32'(CAL_WAIT_CYCLES - 1)) begin
          state_nxt = cal_seq_pkg::HOST_READY; // R8
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      cal_seq_pkg::HOST_READY: begin
        if (recal_req_in) begin
          state_nxt = cal_seq_pkg::HOST_RESET; // R10
          cnt_nxt = 32'h0000_0000;
        end
      end
      cal_seq_pkg::HOST_RESET: begin
        if (cnt_r >= 32'(`RESET_LOW_MIN_CYCLES - 1)) begin
          state_nxt = cal_seq_pkg::HOST_WAIT; // R14
          cnt_nxt = 32'h0000_0000;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= cal_seq_pkg::HOST_POWERUP;
      cnt_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Open-drain reset: drive low only, release lets pull-up win
  assign link.cal_reset_n_o = 1'b0;
  assign link.cal_reset_n_oe = (state_r == cal_seq_pkg::HOST_POWERUP) ||
    (state_r == cal_seq_pkg::HOST_RESET); // R9 R14
  assign link.serial_data_out = 1'b1; // R9
  // No serial transactions issued by this end, so pacing limits hold trivially
  assign link.serial_select_n = 1'b1; // R9 R11 R12 R13

  always_comb begin
    data_nxt = link.sample_data;
    valid_nxt = link.sample_valid && (state_r == cal_seq_pkg::HOST_READY); // R8
    or_nxt = link.over_range;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_r <= '0;
      valid_r <= 1'b0;
      or_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      valid_r <= valid_nxt;
      or_r <= or_nxt;
    end
  end

  assign data_trusted_out = (state_r == cal_seq_pkg::HOST_READY);
  assign sample_data_out = data_r;
  assign sample_valid_out = valid_r;
  assign overrange_out = or_r;
endmodule

// ---- cal_device.sv ----
`timescale 1ns/10ps
`include "cal_seq_params.svh"
// Behaviour
// [R1] Output sample 7.5 clocks after conversion start
// [R2] Power-on detector starts calibration automatically
// [R3] Calibration starts on reset rising edge
// [R4] Over-range high from reset low to done
// [R5] After calibration, over-range shows real overrange
// [R6] Output clock low while reset asserted; code gates it from the first edge after assertion
// [R7] Output clock restarts first edge after release
// [R8] Calibration nominal 200 ms, max 550 ms
// [R9] Host: stable clock, data-out high, no serial
// [R10] Host may recalibrate later via user reset
// [R11] Serial clock period 16 write, 66 read
// [R12] Serial port unrelated to sample clock
// [R13] Sleep mode needs 150 us select setup
// [R14] Recalibrate: hold reset low one cycle
module cal_device #(
  parameter int DATA_W = 12,
  parameter longint CAL_CYCLES = `CAL_NOM_CYCLES,
  parameter int LATENCY = `LATENCY_FULL_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic supplies_good_in,
  input wire logic [DATA_W-1:0] conv_data_in,
  input wire logic conv_overrange_in,
  cal_link_if.device link,
  output logic cal_busy_out,
  output logic cal_fault_out
);
  cal_seq_pkg::dev_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic por_done_r, por_done_nxt;
  logic rstn_line;
  logic fault_r, fault_nxt;
  logic clk_en_r, clk_en_nxt;
  // Input capture stage plus LATENCY stages, so sample edge to output is LATENCY and a half
  logic [DATA_W-1:0] pipe_r [LATENCY+1];
  // Unpacked so each generated process owns its own element
  logic or_pipe_r [LATENCY+1];
  logic [DATA_W-1:0] data_hold_r;
  logic or_out_r, or_out_nxt;

  // Wired-AND line with internal pull-up; power-on detector holds it low
  assign rstn_line = !(link.cal_reset_n_oe && !link.cal_reset_n_o) && por_done_r; // R2

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    por_done_nxt = por_done_r | supplies_good_in; // R2
    fault_nxt = fault_r;
    unique case (state_r)
      cal_seq_pkg::DEV_HOLD: begin
        cnt_nxt = 32'h0000_0000;
        if (rstn_line) begin
          state_nxt = cal_seq_pkg::DEV_CAL; // R3
          // Calibration is corrupt if data-out was pulled low or the port was in use
          fault_nxt = !link.serial_data_out || !link.serial_select_n; // R9
        end
      end
      cal_seq_pkg::DEV_CAL: begin
        if (!rstn_line) begin
          state_nxt = cal_seq_pkg::DEV_HOLD; // R14
        end else if (cnt_r >= 32'(CAL_CYCLES - 1)) begin
          state_nxt = cal_seq_pkg::DEV_RUN; // R8
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      cal_seq_pkg::DEV_RUN: begin
        if (!rstn_line) begin
          state_nxt = cal_seq_pkg::DEV_HOLD; // R10
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= cal_seq_pkg::DEV_HOLD;
      cnt_r <= 32'h0000_0000;
      por_done_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      por_done_r <= por_done_nxt;
      fault_r <= fault_nxt;
    end
  end

  // Forwarded clock gated low from the first edge after reset asserts, enabled on first edge after release
  always_comb begin
    clk_en_nxt = rstn_line; // R6 R7
    or_out_nxt = (state_r != cal_seq_pkg::DEV_RUN) || !rstn_line ? 1'b1 : or_pipe_r[LATENCY-1]; // R4 R5
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      clk_en_r <= 1'b0;
      or_out_r <= 1'b1;
    end else begin
      clk_en_r <= clk_en_nxt;
      or_out_r <= or_out_nxt;
    end
  end

  // Integer stages of the pipeline; last half period from the falling-edge hold
  genvar i;
  generate
    for (i = 0; i <= LATENCY; i++) begin : g_pipe
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          pipe_r[i] <= '0;
          or_pipe_r[i] <= 1'b0;
        end else begin
          pipe_r[i] <= (i == 0) ? conv_data_in : pipe_r[(i == 0) ? 0 : i - 1]; // R1
          or_pipe_r[i] <= (i == 0) ? conv_overrange_in : or_pipe_r[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // Half-cycle retime gives the 7.5 period latency
  always_ff @(negedge core_clk_in) begin
    if (rst_in) begin
      data_hold_r <= '0;
    end else begin
      data_hold_r <= pipe_r[LATENCY]; // R1
    end
  end

  assign link.forwarded_output_clock = clk_en_r & core_clk_in; // R6 R7
  assign link.sample_data = data_hold_r;
  assign link.sample_valid = (state_r == cal_seq_pkg::DEV_RUN);
  assign link.over_range = or_out_r; // R4 R5
  assign cal_busy_out = (state_r != cal_seq_pkg::DEV_RUN);
  assign cal_fault_out = fault_r;
endmodule

// ---- cal_seq_props.sv ----
`timescale 1ns/10ps
module cal_seq_props #(parameter longint CAL_CYCLES = 20) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic cal_reset_n_oe,
  input wire logic serial_data_out,
  input wire logic serial_select_n,
  input wire logic over_range,
  input wire logic forwarded_output_clock,
  input wire logic sample_valid
);
  // Cycles since the line rose, cleared once running
  longint wait_r;
  longint wait_nxt;
  always_comb begin
    wait_nxt = (cal_reset_n_oe || sample_valid) ? 0 : wait_r + 1;
  end
  always_ff @(posedge core_clk_in) begin
    wait_r <= rst_in ? 0 : wait_nxt;
  end
  or_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cal_reset_n_oe |-> ##[1:2] over_range) else $error("over range not raised");
  or_busy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !sample_valid && $past(!sample_valid) |-> over_range) else $error("over range low in calibration");
  // Sampled at the falling edge, so the gated clock shows its high phase
  clk_low_a: assert property (@(negedge core_clk_in) disable iff (rst_in)
    cal_reset_n_oe |=> !forwarded_output_clock) else $error("output clock runs in reset");
  clk_run_a: assert property (@(negedge core_clk_in) disable iff (rst_in)
    $fell(cal_reset_n_oe) |-> ##[1:2] forwarded_output_clock) else $error("output clock not restarted");
  clk_toggle_a: assert property (@(negedge core_clk_in) disable iff (rst_in)
    sample_valid |-> forwarded_output_clock) else $error("output clock stopped while running");
  cal_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(sample_valid) |-> wait_r >= CAL_CYCLES && wait_r <= CAL_CYCLES + 2) else $error("calibration length off");
  cal_bound_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wait_r <= CAL_CYCLES + 3) else $error("calibration overran");
  sdo_high_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    serial_data_out && serial_select_n) else $error("serial lines not idle");
endmodule

// ---- adc_calibration_reset_sequencer_tb.sv ----
`timescale 1ns/10ps
module adc_calibration_reset_sequencer_tb;
  localparam int CAL = 20;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic recal_req_in = 1'b0;
  logic supplies_good_in = 1'b1;
  logic [11:0] conv_data_in = 12'h000;
  logic conv_overrange_in = 1'b0;
  logic trusted;
  logic busy;
  logic fault;
  logic [11:0] host_data;
  logic host_valid;
  logic host_or;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  cal_link_if #(.DATA_W(12)) cal_link_if_inst ();
  cal_host #(.DATA_W(12), .CAL_WAIT_CYCLES(30)) cal_host_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .recal_req_in(recal_req_in), .link(cal_link_if_inst.host), .data_trusted_out(trusted),
    .sample_data_out(host_data), .sample_valid_out(host_valid), .overrange_out(host_or));
  cal_device #(.DATA_W(12), .CAL_CYCLES(CAL)) cal_device_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .supplies_good_in(supplies_good_in), .conv_data_in(conv_data_in), .conv_overrange_in(conv_overrange_in),
    .link(cal_link_if_inst.device), .cal_busy_out(busy), .cal_fault_out(fault));
  cal_seq_props #(.CAL_CYCLES(CAL)) cal_seq_props_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .cal_reset_n_oe(cal_link_if_inst.cal_reset_n_oe), .serial_data_out(cal_link_if_inst.serial_data_out),
    .serial_select_n(cal_link_if_inst.serial_select_n), .over_range(cal_link_if_inst.over_range),
    .forwarded_output_clock(cal_link_if_inst.forwarded_output_clock),
    .sample_valid(cal_link_if_inst.sample_valid));
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    tick(16);
    rst_in = 1'b0;
  endtask
  // Pick 1 waits for running, 0 for the host trusting data
  task automatic wait_for(input bit pick, input int limit);
    n = 0;
    while ((pick ? cal_link_if_inst.sample_valid : trusted) !== 1'b1) begin
      tick(1);
      n++;
      if (n > limit) begin
        bad_count++;
        wrap_up();
      end
    end
  endtask
  initial begin
    do_reset();
    check(cal_link_if_inst.over_range, 1'b1);
    wait_for(1'b0, 200);
    check(n >= 30, 1'b1);
    check(cal_link_if_inst.over_range, 1'b0);
    check(fault, 1'b0);
    for (int i = 0; i < 16; i++) begin
      conv_data_in = 12'h0a0 + 12'(i);
      @(negedge core_clk_in);
      #1;
      if (i >= 8) check(cal_link_if_inst.sample_data, 12'h0a0 + 12'(i - 8));
      if (i >= 9) check(host_data, 12'h0a0 + 12'(i - 9));
      if (i >= 9) check(host_valid, 1'b1);
      tick(1);
    end
    // Input held over range hides the end of calibration
    conv_overrange_in = 1'b1;
    recal_req_in = 1'b1;
    tick(2);
    recal_req_in = 1'b0;
    tick(3);
    check(cal_link_if_inst.over_range, 1'b1);
    check(busy, 1'b1);
    check(trusted, 1'b0);
    wait_for(1'b1, 100);
    tick(12);
    check(cal_link_if_inst.over_range, 1'b1);
    check(host_or, 1'b1);
    conv_overrange_in = 1'b0;
    tick(12);
    check(cal_link_if_inst.over_range, 1'b0);
    check(host_or, 1'b0);
    wait_for(1'b0, 100);
    recal_req_in = 1'b1;
    tick(2);
    recal_req_in = 1'b0;
    tick(8);
    do_reset();
    wait_for(1'b0, 200);
    check(cal_link_if_inst.over_range, 1'b0);
    check(busy, 1'b0);
    wrap_up();
  end
endmodule
